// file: tfp_timer.v
`timescale 1ns/100ps
`include "tfp_regs.vh"
// Contract
// - Free-running mode increments the counter every count clock, ignoring matches.
// - After the maximum value, next count clock wraps to zero; it sets overflow only in free-running mode.
// - Register A as compare and equal to counter asserts interrupt A.
// - Register B as compare and equal to counter asserts interrupt B.
// - Compare matches never clear the counter in free-running mode.
// - Register A capture triggers on valid edge of input A or input B.
// - Register B capture triggers only on valid edge of input A.
// - Both compare: output toggles on every A match and every B match.
// - A compare, B capture: input A edge loads B, asserts interrupt B.
// - Both capture: no toggle unless edge-toggle bit set, then toggle on A edge.
// - Both capture: A edge loads B; B edge loads A only when the register A source bit selects input B.
// - Both capture with only input B edges enabled: register B never captures.
// - PPG mode restarts counter after each A match; A sets period, B width.
// - PPG period is register A plus one count clocks.
// - PPG duty is register B plus one over register A plus one.
// - PPG: A match asserts interrupt A; B match asserts interrupt B, no clear.
// - Reading the counter returns the count without disturbing counting.
// - Free-running supports compare/compare, compare/capture and capture/capture.
// - Input B valid edge chosen by two-bit field in prescaler mode register.
module tfp_timer #(
  parameter CNT_W = 16,
  parameter DIV_W = 8
) (
  input  wire                   mclk,
  input  wire                   rst_n,
  input  wire [`TFP_ADDR_W-1:0] addr,
  input  wire [15:0]            wdata,
  input  wire                   wr_stb,
  input  wire                   rd_stb,
  output reg  [15:0]            rdata,
  input  wire                   edge_input_a,
  input  wire                   edge_input_b,
  output reg                    timer_output,
  output reg                    timer_output_oe_n,
  output reg                    irq_a,
  output reg                    irq_b
);

  reg  [CNT_W-1:0] count_value_q;
  reg  [CNT_W-1:0] capture_compare_a_q;
  reg  [CNT_W-1:0] capture_compare_b_q;
  reg  [3:0]       mode_control_reg_q;
  reg  [2:0]       capture_compare_control_reg_q;
  reg  [3:0]       prescaler_mode_reg_q;
  reg  [1:0]       output_control_reg_q;
  reg  [DIV_W-1:0] clk_div_q;
  reg  [DIV_W-1:0] div_cnt_q;
  reg              tick_q;
  reg  [1:0]       sync_a_q;
  reg  [1:0]       sync_b_q;
  reg              prev_a_q;
  reg              prev_b_q;
  reg              out_level_q;
  wire [1:0]       op_mode;
  wire             edge_toggle_enable;
  wire             a_is_cap;
  wire             b_is_cap;
  wire             a_src_b;
  wire             ev_a;
  wire             ev_b;
  wire             match_a;
  wire             match_b;
  wire             running;
  wire             at_max;
  wire             ovf_clr;
  reg              cap_a_trig;
  reg              toggle;

  assign op_mode            = mode_control_reg_q[3:2];
  assign edge_toggle_enable = mode_control_reg_q[`TFP_MODE_TOGGLE];
  assign a_is_cap           = capture_compare_control_reg_q[`TFP_CC_A_CAP];
  assign a_src_b            = capture_compare_control_reg_q[`TFP_CC_A_SRC_B];
  assign b_is_cap           = capture_compare_control_reg_q[`TFP_CC_B_CAP];
  assign running            = (op_mode == `TFP_MODE_FREE) || (op_mode == `TFP_MODE_PPG);
  assign at_max             = (count_value_q == `TFP_COUNT_MAX);

  // Edge qualifier shared by both inputs.
  function valid_edge;
    input [1:0] sel;
    input       cur;
    input       prv;
    begin
      case (sel)
        `TFP_ES_FALL: valid_edge = prv & ~cur;
        `TFP_ES_RISE: valid_edge = ~prv & cur;
        `TFP_ES_BOTH: valid_edge = prv ^ cur;
        default:      valid_edge = 1'b0;
      endcase
    end
  endfunction

  assign ev_a    = running && valid_edge(prescaler_mode_reg_q[1:0], sync_a_q[1], prev_a_q);
  assign ev_b    = running && valid_edge(prescaler_mode_reg_q[3:2], sync_b_q[1], prev_b_q);
  // Matches are sampled only on count ticks so each match yields one event.
  assign match_a = tick_q && running && !a_is_cap && (count_value_q == capture_compare_a_q);
  assign match_b = tick_q && running && !b_is_cap && (count_value_q == capture_compare_b_q);
  assign ovf_clr = wr_stb && (addr == `TFP_OFF_MODE) && !wdata[`TFP_MODE_OVF];

  always @* begin
    cap_a_trig = a_src_b ? ev_b : ev_a;
    toggle     = match_a | match_b;
    if (a_is_cap && b_is_cap) begin
      toggle = edge_toggle_enable & ev_a;
    end
  end

  // Count clock divider: one-cycle enable every clk_div_q+1 cycles.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= {DIV_W{1'b0}};
      tick_q    <= 1'b0;
    end else if (div_cnt_q >= clk_div_q) begin
      div_cnt_q <= {DIV_W{1'b0}};
      tick_q    <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
      tick_q    <= 1'b0;
    end
  end

  // Three flops per input; the second and third stages feed edge detection.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_q <= 2'h0;
      sync_b_q <= 2'h0;
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
    end else begin
      sync_a_q <= {sync_a_q[0], edge_input_a};
      sync_b_q <= {sync_b_q[0], edge_input_b};
      prev_a_q <= sync_a_q[1];
      prev_b_q <= sync_b_q[1];
    end
  end

  // Counter; a PPG match on register A restarts it, other matches never do.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_q <= {CNT_W{1'b0}};
    end else if (!running) begin
      count_value_q <= {CNT_W{1'b0}};
    end else if (tick_q) begin
      if (op_mode == `TFP_MODE_PPG && match_a) begin
        count_value_q <= {CNT_W{1'b0}};
      end else begin
        count_value_q <= count_value_q + 1'b1;
      end
    end
  end

  // Registers, captures and overflow flag; hardware capture wins over a same-cycle write.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_compare_a_q           <= {CNT_W{1'b0}};
      capture_compare_b_q           <= {CNT_W{1'b0}};
      mode_control_reg_q            <= 4'h0;
      capture_compare_control_reg_q <= 3'h0;
      prescaler_mode_reg_q          <= 4'h0;
      output_control_reg_q          <= 2'h0;
      clk_div_q                     <= {DIV_W{1'b0}};
    end else begin
      if (wr_stb) begin
        if (addr == `TFP_OFF_CCA) begin
          capture_compare_a_q <= wdata[CNT_W-1:0];
        end else if (addr == `TFP_OFF_CCB) begin
          capture_compare_b_q <= wdata[CNT_W-1:0];
        end else if (addr == `TFP_OFF_MODE) begin
          mode_control_reg_q[3:1] <= wdata[3:1];
          clk_div_q               <= wdata[8+DIV_W-1:8];
        end else if (addr == `TFP_OFF_CCCTL) begin
          capture_compare_control_reg_q <= wdata[2:0];
        end else if (addr == `TFP_OFF_PRESC) begin
          prescaler_mode_reg_q <= wdata[3:0];
        end else if (addr == `TFP_OFF_OUTCTL) begin
          output_control_reg_q <= wdata[1:0];
        end
      end
      if (a_is_cap && cap_a_trig) begin
        capture_compare_a_q <= count_value_q;
      end
      if (b_is_cap && ev_a) begin
        capture_compare_b_q <= count_value_q;
      end
      if (tick_q && running && at_max && op_mode == `TFP_MODE_FREE) begin
        mode_control_reg_q[`TFP_MODE_OVF] <= 1'b1;
      end else if (ovf_clr) begin
        mode_control_reg_q[`TFP_MODE_OVF] <= 1'b0;
      end
    end
  end

  // Interrupt pulses and timer output.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_a             <= 1'b0;
      irq_b             <= 1'b0;
      out_level_q       <= 1'b0;
      timer_output      <= 1'b0;
      timer_output_oe_n <= 1'b1;
    end else begin
      irq_a <= match_a | (a_is_cap & cap_a_trig);
      irq_b <= match_b | (b_is_cap & ev_a);
      if (!running) begin
        out_level_q <= 1'b0;
      end else if (op_mode == `TFP_MODE_PPG && tick_q) begin
        // High from restart through the B match gives width B+1 of period A+1.
        if (match_a) begin
          out_level_q <= 1'b1;
        end else if (match_b) begin
          out_level_q <= 1'b0;
        end
      end else if (op_mode == `TFP_MODE_FREE && toggle) begin
        out_level_q <= ~out_level_q;
      end
      timer_output      <= out_level_q & output_control_reg_q[`TFP_OC_ENA_BIT];
      timer_output_oe_n <= ~output_control_reg_q[`TFP_OC_ENABLE];
    end
  end

  // Read port; data valid the cycle after the strobe, zero otherwise.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (!rd_stb) begin
      rdata <= 16'h0000;
    end else if (addr == `TFP_OFF_COUNT) begin
      rdata <= count_value_q;
    end else if (addr == `TFP_OFF_CCA) begin
      rdata <= capture_compare_a_q;
    end else if (addr == `TFP_OFF_CCB) begin
      rdata <= capture_compare_b_q;
    end else if (addr == `TFP_OFF_MODE) begin
      rdata <= {clk_div_q, 4'h0, mode_control_reg_q};
    end else if (addr == `TFP_OFF_CCCTL) begin
      rdata <= {13'h0000, capture_compare_control_reg_q};
    end else if (addr == `TFP_OFF_PRESC) begin
      rdata <= {12'h000, prescaler_mode_reg_q};
    end else if (addr == `TFP_OFF_OUTCTL) begin
      rdata <= {14'h0000, output_control_reg_q};
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule

// file: tfp_regs.vh
`ifndef TFP_REGS_VH
`define TFP_REGS_VH
`define TFP_ADDR_W        4
`define TFP_OFF_COUNT     4'h0
`define TFP_OFF_CCA       4'h1
`define TFP_OFF_CCB       4'h2
`define TFP_OFF_MODE      4'h3
`define TFP_OFF_CCCTL     4'h4
`define TFP_OFF_PRESC     4'h5
`define TFP_OFF_OUTCTL    4'h6
`define TFP_MODE_STOP     2'h0
`define TFP_MODE_FREE     2'h1
`define TFP_MODE_PPG      2'h3
`define TFP_MODE_TOGGLE   1
`define TFP_MODE_OVF      0
`define TFP_CC_A_CAP      0
`define TFP_CC_A_SRC_B    1
`define TFP_CC_B_CAP      2
`define TFP_PR_ESA_LO     0
`define TFP_PR_ESB_LO     2
`define TFP_OC_ENABLE     0
`define TFP_OC_ENA_BIT    1
`define TFP_ES_FALL       2'h0
`define TFP_ES_RISE       2'h1
`define TFP_ES_NONE       2'h2
`define TFP_ES_BOTH       2'h3
`define TFP_COUNT_MAX     16'hffff
`define TFP_COUNT_ZERO    16'h0000
`endif

// file: tfp_timer_monitor.sv
`timescale 1ns/100ps
`include "tfp_regs.vh"
module tfp_timer_monitor (
  input wire                   mclk,
  input wire                   rst_n,
  input wire [`TFP_ADDR_W-1:0] addr,
  input wire [15:0]            wdata,
  input wire                   wr_stb,
  input wire                   rd_stb,
  input wire [15:0]            rdata,
  input wire                   timer_output,
  input wire                   irq_a,
  input wire                   irq_b
);
  reg  [15:0] mode_q, a_q, b_q;
  reg  [3:0]  pr_q, cc_q, oc_q;
  reg  [5:0]  age_q;
  reg  [16:0] gap_q, hi_q;
  // Judged only after a quiet spell, so events still in the edge pipeline are not misread.
  wire free = mode_q[15:8] == 8'h00 && mode_q[3:2] == `TFP_MODE_FREE;
  wire ppg  = mode_q[15:8] == 8'h00 && mode_q[3:2] == `TFP_MODE_PPG && cc_q == 4'h0 && oc_q[1] && &age_q;
  wire cap2 = free && cc_q[0] && cc_q[2] && !mode_q[1] && &age_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {mode_q, a_q, b_q, pr_q, cc_q, oc_q, age_q, gap_q, hi_q} <= 100'h0;
    end else begin
      gap_q <= irq_a ? 17'h00001 : gap_q + 17'h00001;
      hi_q  <= timer_output ? hi_q + 17'h00001 : 17'h00000;
      age_q <= wr_stb ? 6'h00 : age_q + {5'h00, ~&age_q};
      if (wr_stb && addr == `TFP_OFF_MODE) mode_q <= wdata;
      if (wr_stb && addr == `TFP_OFF_CCA) a_q <= wdata;
      if (wr_stb && addr == `TFP_OFF_CCB) b_q <= wdata;
      if (wr_stb && addr == `TFP_OFF_CCCTL) cc_q <= wdata[3:0];
      if (wr_stb && addr == `TFP_OFF_PRESC) pr_q <= wdata[3:0];
      if (wr_stb && addr == `TFP_OFF_OUTCTL) oc_q <= wdata[3:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence two_reads;
    rd_stb && addr == `TFP_OFF_COUNT ##1 rd_stb && addr == `TFP_OFF_COUNT;
  endsequence
  sequence ppg_fall;
    ppg ##0 $fell(timer_output);
  endsequence
  count_step_a: assert property (free && &age_q ##0 two_reads |=> rdata == $past(rdata) + 16'h0001)
    else $error("count did not advance by one between reads");
  irqa_pulse_a: assert property (irq_a |=> !irq_a)
    else $error("irq_a longer than one cycle");
  irqb_pulse_a: assert property (irq_b |=> !irq_b)
    else $error("irq_b longer than one cycle");
  cmp_toggle_a: assert property (irq_a && free && cc_q == 4'h0 && oc_q[1] && &age_q |-> ##[0:2] timer_output != $past(timer_output))
    else $error("output did not toggle on match");
  hold_cap_a: assert property (cap2 |=> $stable(timer_output))
    else $error("output moved with both registers capturing");
  no_capb_a: assert property (cap2 && pr_q[1:0] == `TFP_ES_NONE |-> !irq_b)
    else $error("register b captured without input a edges");
  ppg_period_a: assert property (irq_a && ppg |-> gap_q == {1'b0, a_q} + 17'h00001)
    else $error("pulse period wrong");
  ppg_bmatch_a: assert property (irq_b && ppg |-> gap_q == {1'b0, b_q} + 17'h00001)
    else $error("width match at wrong time");
  ppg_width_a: assert property (ppg_fall |-> hi_q == {1'b0, b_q} + 17'h00001)
    else $error("pulse width wrong");
endmodule
bind tfp_timer tfp_timer_monitor mon_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .timer_output(timer_output), .irq_a(irq_a), .irq_b(irq_b));

// file: tfp_edge_model.sv
`timescale 1ns/100ps
module tfp_edge_model (
  input  wire mclk,
  input  wire rst_n,
  input  wire flip_a,
  input  wire flip_b,
  output reg  edge_input_a,
  output reg  edge_input_b
);
  // Levels change only after a clock edge, so each one lasts whole cycles for the synchroniser.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_input_a <= 1'b0;
      edge_input_b <= 1'b0;
    end else begin
      edge_input_a <= edge_input_a ^ flip_a;
      edge_input_b <= edge_input_b ^ flip_b;
    end
  end
endmodule

// file: timer16_freerun_ppg_test.sv
`timescale 1ns/100ps
`include "tfp_regs.vh"
module timer16_freerun_ppg_test;
  reg         mclk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, flip_a = 1'b0, flip_b = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [15:0] wdata = 16'h0000, rv, r1, c1, c2;
  wire [15:0] rdata;
  wire        tout, oe_n, irq_a, irq_b, ein_a, ein_b;
  integer     error_cnt = 0, n_compared = 0, cyc = 0, t0, i;
  tfp_timer dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .edge_input_a(ein_a), .edge_input_b(ein_b), .timer_output(tout),
    .timer_output_oe_n(oe_n), .irq_a(irq_a), .irq_b(irq_b));
  tfp_edge_model edge_u (.mclk(mclk), .rst_n(rst_n), .flip_a(flip_a), .flip_b(flip_b),
    .edge_input_a(ein_a), .edge_input_b(ein_b));
  always #2.5 mclk = ~mclk;
  task tally_and_finish;
    begin
      if (error_cnt == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      addr <= a; wdata <= d; wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      // One idle edge keeps the strobe from being lowered and raised in one time step.
      @(posedge mclk);
    end
  endtask
  task rd(input [3:0] a);
    begin
      addr <= a; rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 rv = rdata;
      @(posedge mclk);
    end
  endtask
  task wirq(input s, input integer lim);
    begin
      #1 i = 0;
      while ((s ? irq_b : irq_a) !== 1'b1 && i < lim) begin
        @(posedge mclk);
        #1 i = i + 1;
      end
      chk(s ? "irq_b seen" : "irq_a seen", 16'h0001, {15'h0, i < lim});
    end
  endtask
  task pulse(input s);
    begin
      flip_a <= !s; flip_b <= s;
      @(posedge mclk);
      {flip_a, flip_b} <= 2'b00;
      repeat (8) @(posedge mclk);
      flip_a <= !s; flip_b <= s;
      @(posedge mclk);
      {flip_a, flip_b} <= 2'b00;
      repeat (8) @(posedge mclk);
    end
  endtask
  task t_regs;
    begin
      wr(`TFP_OFF_CCA, 16'h5a3c);
      wr(4'h7, 16'hffff);
      rd(`TFP_OFF_CCA); chk("reg a", 16'h5a3c, rv);
      rd(4'h7); chk("unmapped", 16'h0000, rv);
    end
  endtask
  task t_free;
    begin
      wr(`TFP_OFF_CCA, 16'h0100);
      wr(`TFP_OFF_CCB, 16'h8000);
      wr(`TFP_OFF_OUTCTL, 16'h0002);
      wr(`TFP_OFF_MODE, 16'h0004);
      t0 = cyc;
      repeat (70) @(posedge mclk);
      addr <= `TFP_OFF_COUNT; rd_stb <= 1'b1;
      @(posedge mclk);
      #1 r1 = rdata;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 chk("count step", r1 + 16'h0001, rdata);
      @(posedge mclk);
      wirq(1'b0, 300);
      wirq(1'b1, 33000);
      while (cyc < t0 + 65500) @(posedge mclk);
      rd(`TFP_OFF_MODE); chk("overflow early", 16'h0000, {15'h0, rv[0]});
      while (cyc < t0 + 65560) @(posedge mclk);
      rd(`TFP_OFF_MODE); chk("overflow set", 16'h0001, {15'h0, rv[0]});
      rd(`TFP_OFF_COUNT); chk("count wrapped", 16'h0001, {15'h0, rv < 16'h0100});
      wr(`TFP_OFF_MODE, 16'h0004);
      rd(`TFP_OFF_MODE); chk("overflow cleared", 16'h0000, {15'h0, rv[0]});
    end
  endtask
  task t_cap;
    begin
      wr(`TFP_OFF_OUTCTL, 16'h0000);
      wr(`TFP_OFF_PRESC, 16'h0005);
      wr(`TFP_OFF_CCCTL, 16'h0007);
      rd(`TFP_OFF_CCCTL); chk("roles", 16'h0007, rv);
      chk("drive off", 16'h0001, {15'h0, oe_n});
      repeat (70) @(posedge mclk);
      rd(`TFP_OFF_COUNT); c1 = rv;
      pulse(1'b1);
      rd(`TFP_OFF_COUNT); c2 = rv;
      rd(`TFP_OFF_CCA); r1 = rv; chk("a from input b", 16'h0001, {15'h0, rv > c1 && rv < c2});
      rd(`TFP_OFF_CCB); chk("b untouched", 16'h8000, rv);
      rd(`TFP_OFF_COUNT); c1 = rv;
      pulse(1'b0);
      rd(`TFP_OFF_COUNT); c2 = rv;
      rd(`TFP_OFF_CCB); chk("b from input a", 16'h0001, {15'h0, rv > c1 && rv < c2});
      rd(`TFP_OFF_CCA); chk("a untouched", r1, rv);
      wr(`TFP_OFF_PRESC, 16'h0006);
      repeat (70) @(posedge mclk);
      pulse(1'b0);
      rd(`TFP_OFF_CCB); chk("b no capture", c1 + 16'h0001, {15'h0, rv > c1 && rv < c2} + c1);
    end
  endtask
  task t_mix;
    begin
      wr(`TFP_OFF_PRESC, 16'h0003);
      wr(`TFP_OFF_CCCTL, 16'h0004);
      rd(`TFP_OFF_COUNT); c1 = rv;
      flip_a <= 1'b1;
      @(posedge mclk);
      flip_a <= 1'b0;
      wirq(1'b1, 8);
      @(posedge mclk);
      rd(`TFP_OFF_CCB); chk("b on a edge", 16'h0001, {15'h0, rv > c1 && rv < c1 + 16'h0010});
    end
  endtask
  task t_ppg;
    begin
      wr(`TFP_OFF_MODE, 16'h0000);
      wr(`TFP_OFF_CCCTL, 16'h0000);
      wr(`TFP_OFF_OUTCTL, 16'h0003);
      wr(`TFP_OFF_CCA, 16'h0009);
      wr(`TFP_OFF_CCB, 16'h0003);
      wr(`TFP_OFF_MODE, 16'h000c);
      repeat (100) @(posedge mclk);
      c1 = 16'h0000;
      repeat (40) begin
        @(posedge mclk);
        #1 if (tout === 1'b1) c1 = c1 + 16'h0001;
      end
      chk("ppg high cycles", 16'h0010, c1);
      chk("drive on", 16'h0000, {15'h0, oe_n});
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_free;
    t_cap;
    t_mix;
    t_ppg;
    tally_and_finish;
  end
endmodule
